/* rtl/smpc_stop_mode_power_controller.v */
// Function
// R1 - stop with stop enable clear raises an illegal-opcode reset
// R2 - debug enabled: stop enters stop3 keeping debug alive, never stop2
// R3 - both lowvolt enables set, no debug: stop3 with regulator active
// R4 - otherwise partial powerdown control picks stop3 (0) or stop2 (1)
// R5 - lowvolt enables sampled at stop; enabled turns stop2 into stop3
// R6 - no stop1 mode exists; only stop2 and stop3
// R7 - any stop halts bus and cpu clocks; refclk may keep running
// R8 - peripheral clocks halt in every stop, even with debug enabled
// R9 - stop3 keeps register, ram state and holds pin states
// R10 - stop3 exits on reset pin or async serial, converter, warning, irq
// R11 - reset pin exit takes reset vector; interrupt exit takes its vector
// R12 - debug enabled at stop keeps debug clocks and full regulation
// R13 - while stopped, status memory commands skip access, return error
// R14 - background command in stop with debug enabled enters background
// R15 - stop2 powers down all but ram and latches pin controls
// R16 - stop2 exits only on reset pin or irq pin
// R17 - stop2 wake acts as power-on reset with low trip lowvolt reset
// R18 - stop2 wake sets powerdown flag, pins latched until ack written 1
// R19 - on ack pins follow port registers unless a peripheral drives them
// R20 - software restores ports and peripherals before acknowledging
// R21 - converter runs in stop3 only with async clock and lowvolt enabled
// R22 - clock source runs in stop3 only with both refclk enables set
// R23 - wait stops cpu clock, clears mask; any interrupt resumes cpu
// R24 - stop3 exit restores bus and cpu clocks before vector fetch
`include "smpc_defs.vh"
`default_nettype none

module smpc_stop_mode_power_controller (
    // clock and reset
    input wire clock,
    input wire rst,
    // cpu instruction events
    input wire stop_exec,
    input wire wait_exec,
    // configuration bits
    input wire stop_enable_bit,
    input wire debug_enable_bit,
    input wire lowvolt_detect_enable,
    input wire lowvolt_detect_stop_enable,
    input wire partial_powerdown_control,
    input wire partial_powerdown_ack,
    input wire internal_refclk_enable,
    input wire internal_ref_stop_enable,
    input wire adc_async_clk_sel,
    // wakeup sources
    input wire reset_pin_n,
    input wire irq_pin_n,
    input wire sci_async_irq,
    input wire adc_async_irq,
    input wire low_voltage_warning_irq,
    input wire irq_async_irq,
    input wire any_irq_req,
    input wire supply_low,
    // debug host
    input wire bgnd_cmd,
    input wire mem_stat_cmd,
    // pin control
    input wire [7:0] port_ctrl,
    input wire [7:0] periph_en,
    input wire [7:0] periph_ctrl,
    // clock and power gating
    output reg bus_clk_en,
    output reg cpu_clk_en,
    output reg periph_clk_en,
    output reg debug_clk_en,
    output reg refclk_run,
    output reg adc_run,
    output reg regulator_full,
    output reg core_power_on,
    // resets and vectors
    output reg illegal_op_reset,
    output reg por_reset,
    output reg lvd_reset_en,
    output reg lvd_low_trip,
    output reg take_reset_vec,
    output reg take_irq_vec,
    output reg clear_int_mask,
    output reg enter_bgnd,
    // debug answers
    output reg mem_access_en,
    output reg [1:0] mem_stat,
    // status and pins
    output reg [1:0] mode_o,
    output reg partial_powerdown_flag,
    output reg [7:0] pin_ctrl_o
);

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [3:0] cnt_q;
    reg [3:0] cnt_d;
    reg via_irq_q;
    reg via_irq_d;
    reg dbg_keep_q;
    reg dbg_keep_d;
    reg lvd_stop_q;
    reg lvd_stop_d;
    reg latch_q;
    reg [7:0] held_q;
    wire [7:0] live_ctrl;
    wire lvd_for_stop;
    wire async_wake;
    wire stopped;

    assign lvd_for_stop = lowvolt_detect_enable & lowvolt_detect_stop_enable;
    assign async_wake = sci_async_irq | adc_async_irq |
        low_voltage_warning_irq | irq_async_irq; // [R10]
    assign stopped = (state_q == `SMPC_ST_STOP3) ||
        (state_q == `SMPC_ST_STOP2);

    // per pin: enabled peripheral wins over port register
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_pin
            assign live_ctrl[gi] = periph_en[gi] ? periph_ctrl[gi] :
                port_ctrl[gi]; // [R19]
        end
    endgenerate

    // next state; stop1 never appears among the states [R6]
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        via_irq_d = via_irq_q;
        dbg_keep_d = dbg_keep_q;
        lvd_stop_d = lvd_stop_q;
        case (state_q)
            `SMPC_ST_RUN:
            begin
                if (stop_exec && stop_enable_bit)
                begin
                    // enables sampled only at the stop instruction [R5]
                    dbg_keep_d = debug_enable_bit; // [R12]
                    lvd_stop_d = lvd_for_stop;
                    if (debug_enable_bit)
                        state_d = `SMPC_ST_STOP3; // [R2]
                    else if (lvd_for_stop)
                        state_d = `SMPC_ST_STOP3; // [R3] [R5]
                    else if (partial_powerdown_control)
                        state_d = `SMPC_ST_STOP2; // [R4]
                    else
                        state_d = `SMPC_ST_STOP3; // [R4]
                end
                else if (wait_exec && !stop_exec)
                    state_d = `SMPC_ST_WAIT; // [R23]
            end
            `SMPC_ST_WAIT:
            begin
                if (bgnd_cmd)
                    state_d = `SMPC_ST_BGND;
                else if (any_irq_req)
                    state_d = `SMPC_ST_RUN; // [R23]
            end
            `SMPC_ST_STOP3:
            begin
                cnt_d = 4'h0;
                if (!reset_pin_n)
                begin
                    via_irq_d = 1'b0; // [R11]
                    state_d = `SMPC_ST_WAKE;
                end
                else if (bgnd_cmd && dbg_keep_q)
                    state_d = `SMPC_ST_BGND; // [R14]
                else if (async_wake)
                begin
                    via_irq_d = 1'b1; // [R11]
                    state_d = `SMPC_ST_WAKE;
                end
            end
            `SMPC_ST_STOP2:
            begin
                cnt_d = 4'h0;
                if (!reset_pin_n || !irq_pin_n)
                    state_d = `SMPC_ST_POR; // [R16]
            end
            `SMPC_ST_WAKE:
            begin
                // clocks come back first, vector fetch after a gap [R24]
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == `SMPC_RESTORE_CYC - 1)
                    state_d = `SMPC_ST_RUN;
            end
            `SMPC_ST_POR:
            begin
                // held in reset while supply stays low [R17]
                if (supply_low)
                    cnt_d = 4'h0;
                else
                    cnt_d = cnt_q + 4'h1;
                if (!supply_low && cnt_q == `SMPC_POR_HOLD_CYC - 1)
                    state_d = `SMPC_ST_RUN;
            end
            `SMPC_ST_BGND:
            begin
                // leaving background is the debug host's job via reset
                state_d = `SMPC_ST_BGND;
            end
            default:
                state_d = `SMPC_ST_RUN;
        endcase
    end
    // state registers
    always @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= `SMPC_ST_RUN;
            cnt_q <= 4'h0;
            via_irq_q <= 1'b0;
            dbg_keep_q <= 1'b0;
            lvd_stop_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            via_irq_q <= via_irq_d;
            dbg_keep_q <= dbg_keep_d;
            lvd_stop_q <= lvd_stop_d;
        end
    end
    // powerdown flag and pin latch; flag set beats a same-cycle ack
    always @(posedge clock)
    begin
        if (rst)
        begin
            partial_powerdown_flag <= `SMPC_PARTIAL_POWERDOWN_FLAG_RST;
            latch_q <= `SMPC_LATCH_RST;
            held_q <= 8'h00;
        end
        else if (state_d == `SMPC_ST_STOP2 && state_q == `SMPC_ST_RUN)
        begin
            latch_q <= 1'b1; // [R15]
            held_q <= live_ctrl;
        end
        else if (state_q == `SMPC_ST_POR && state_d == `SMPC_ST_RUN)
            partial_powerdown_flag <= 1'b1; // [R18]
        else if (partial_powerdown_ack && state_q == `SMPC_ST_RUN)
        begin
            partial_powerdown_flag <= 1'b0; // [R18]
            latch_q <= 1'b0;
        end
    end
    // outputs registered from next state; resets, vectors, status and pins also use current state
    always @(posedge clock)
    begin
        if (rst)
        begin
            bus_clk_en <= 1'b1;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            debug_clk_en <= 1'b1;
            refclk_run <= 1'b1;
            adc_run <= 1'b1;
            regulator_full <= 1'b1;
            core_power_on <= 1'b1;
            illegal_op_reset <= 1'b0;
            por_reset <= 1'b0;
            lvd_reset_en <= 1'b0;
            lvd_low_trip <= 1'b0;
            take_reset_vec <= 1'b0;
            take_irq_vec <= 1'b0;
            clear_int_mask <= 1'b0;
            enter_bgnd <= 1'b0;
            mem_access_en <= 1'b1;
            mem_stat <= `SMPC_DBG_STAT_OK;
            mode_o <= `SMPC_MODE_RUN;
            pin_ctrl_o <= 8'h00;
        end
        else
        begin
            illegal_op_reset <= stop_exec && !stop_enable_bit &&
                state_q == `SMPC_ST_RUN; // [R1]
            // bus and peripheral clocks off only in stop, cpu off in every state but run and wake
            bus_clk_en <= !(state_d == `SMPC_ST_STOP3 ||
                state_d == `SMPC_ST_STOP2); // [R7]
            cpu_clk_en <= state_d == `SMPC_ST_RUN ||
                state_d == `SMPC_ST_WAKE; // [R7] [R24]
            periph_clk_en <= !(state_d == `SMPC_ST_STOP3 ||
                state_d == `SMPC_ST_STOP2); // [R8]
            debug_clk_en <= (state_d != `SMPC_ST_STOP3 &&
                state_d != `SMPC_ST_STOP2) ||
                (state_d == `SMPC_ST_STOP3 && dbg_keep_d); // [R12]
            regulator_full <= state_d != `SMPC_ST_STOP2 &&
                (state_d != `SMPC_ST_STOP3 || dbg_keep_d ||
                lvd_stop_d); // [R3] [R12]
            refclk_run <= state_d == `SMPC_ST_STOP2 ? 1'b0 :
                state_d == `SMPC_ST_STOP3 ?
                (internal_refclk_enable && internal_ref_stop_enable) :
                1'b1; // [R22]
            adc_run <= state_d == `SMPC_ST_STOP2 ? 1'b0 :
                state_d == `SMPC_ST_STOP3 ?
                (adc_async_clk_sel && lvd_stop_d) : 1'b1; // [R21]
            core_power_on <= state_d != `SMPC_ST_STOP2; // [R15] [R9]
            por_reset <= state_d == `SMPC_ST_POR; // [R17]
            if (state_d == `SMPC_ST_POR)
            begin
                lvd_reset_en <= 1'b1; // [R17]
                lvd_low_trip <= 1'b1;
            end
            take_reset_vec <= (state_q == `SMPC_ST_WAKE &&
                state_d == `SMPC_ST_RUN && !via_irq_q) ||
                (state_q == `SMPC_ST_POR &&
                state_d == `SMPC_ST_RUN); // [R11] [R17]
            take_irq_vec <= (state_q == `SMPC_ST_WAKE &&
                state_d == `SMPC_ST_RUN && via_irq_q) ||
                (state_q == `SMPC_ST_WAIT &&
                state_d == `SMPC_ST_RUN); // [R11] [R23]
            clear_int_mask <= state_q == `SMPC_ST_RUN &&
                state_d == `SMPC_ST_WAIT; // [R23]
            enter_bgnd <= state_q != `SMPC_ST_BGND &&
                state_d == `SMPC_ST_BGND; // [R14]
            // status commands refused while stopped or waiting
            if (mem_stat_cmd)
            begin
                mem_access_en <= !(stopped ||
                    state_q == `SMPC_ST_WAIT); // [R13]
                mem_stat <= (stopped || state_q == `SMPC_ST_WAIT) ?
                    `SMPC_DBG_STAT_STOPWAIT : `SMPC_DBG_STAT_OK; // [R13]
            end
            case (state_d)
                `SMPC_ST_WAIT: mode_o <= `SMPC_MODE_WAIT;
                `SMPC_ST_STOP3: mode_o <= `SMPC_MODE_STOP3;
                `SMPC_ST_STOP2: mode_o <= `SMPC_MODE_STOP2;
                default: mode_o <= `SMPC_MODE_RUN;
            endcase
            // pins held in stop3, latched through stop2 until ack [R9]
            if (latch_q)
                pin_ctrl_o <= held_q; // [R18]
            else if (!stopped)
                pin_ctrl_o <= live_ctrl; // [R19]
        end
    end
endmodule
`default_nettype wire

/* rtl/smpc_defs.vh */
`ifndef SMPC_DEFS_VH
`define SMPC_DEFS_VH

// power state codes
`define SMPC_ST_RUN 3'h0
`define SMPC_ST_WAIT 3'h1
`define SMPC_ST_STOP3 3'h2
`define SMPC_ST_STOP2 3'h3
`define SMPC_ST_WAKE 3'h4
`define SMPC_ST_POR 3'h5
`define SMPC_ST_BGND 3'h6

// reported mode codes on mode_o
`define SMPC_MODE_RUN 2'h0
`define SMPC_MODE_WAIT 2'h1
`define SMPC_MODE_STOP3 2'h2
`define SMPC_MODE_STOP2 2'h3

// timing: power-on style reset hold after stop2 wake, in ns
`define SMPC_CLK_NS 8
`define SMPC_POR_HOLD_NS 64
`define SMPC_POR_HOLD_CYC (`SMPC_POR_HOLD_NS / `SMPC_CLK_NS)
// clock restore delay before first vector fetch after stop3 exit
`define SMPC_RESTORE_NS 16
`define SMPC_RESTORE_CYC \
    ((`SMPC_RESTORE_NS + `SMPC_CLK_NS - 1) / `SMPC_CLK_NS)

// status reported by memory-access-with-status commands while stopped
`define SMPC_DBG_STAT_OK 2'h0
`define SMPC_DBG_STAT_STOPWAIT 2'h2

// reset values
`define SMPC_PARTIAL_POWERDOWN_FLAG_RST 1'b0
`define SMPC_LATCH_RST 1'b0

`endif

/* test/smpc_monitor.sv */
`default_nettype none
module smpc_monitor (
    // clock and reset
    input wire logic clock, rst,
    // cpu events and configuration
    input wire logic stop_exec, stop_enable_bit, debug_enable_bit,
    input wire logic lowvolt_detect_enable, lowvolt_detect_stop_enable,
    input wire logic partial_powerdown_control, partial_powerdown_ack,
    input wire logic internal_refclk_enable, internal_ref_stop_enable,
    // wakeup and debug
    input wire logic adc_async_clk_sel, irq_pin_n, sci_async_irq,
    input wire logic mem_stat_cmd,
    // clocks, power and resets
    input wire logic bus_clk_en, cpu_clk_en, periph_clk_en, refclk_run,
    input wire logic adc_run, core_power_on, illegal_op_reset, por_reset,
    // vectors and status
    input wire logic take_reset_vec, take_irq_vec, mem_access_en,
    input wire logic [1:0] mem_stat,
    input wire logic [1:0] mode_o,
    input wire logic partial_powerdown_flag,
    input wire logic [7:0] pin_ctrl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // expected mode; debug or a stop-enabled detector vetoes stop2
    wire lvd_stop = lowvolt_detect_enable && lowvolt_detect_stop_enable;
    wire [1:0] pick = (debug_enable_bit || lvd_stop) ? 2'h2
        : {1'b1, partial_powerdown_control};
    wire run = mode_o == 2'h0;
    wire go = stop_exec && run;
    wire held = mode_o[1] || partial_powerdown_flag;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_stop_refused:
    assert property (go && !stop_enable_bit |=> illegal_op_reset && run)
        else $error("stop not refused");
    a_mode_pick:
    assert property (go && stop_enable_bit |=> mode_o == $past(pick))
        else $error("wrong stop mode");
    a_clocks_halted:
    assert property (mode_o[1] |-> !(bus_clk_en || cpu_clk_en
        || periph_clk_en)) else $error("clock running in stop");
    a_stop3_optional:
    assert property (mode_o == 2'h2 |-> adc_run == (adc_async_clk_sel
        && lvd_stop) && refclk_run == (internal_refclk_enable
        && internal_ref_stop_enable)) else $error("standby wrong");
    a_status_refused:
    assert property (mode_o == 2'h2 && mem_stat_cmd |=> !mem_access_en
        && mem_stat == 2'h2) else $error("status access allowed");
    a_stop3_wake:
    assert property (mode_o == 2'h2 && sci_async_irq |-> ##[1:6]
        take_irq_vec) else $error("no stop3 wake");
    a_stop2_wake:
    assert property (mode_o == 2'h3 && !irq_pin_n |-> !core_power_on
        ##1 por_reset) else $error("no stop2 wake");
    a_pins_held:
    assert property (held && $past(held) |-> $stable(pin_ctrl_o))
        else $error("pins moved");
    a_flag_set:
    assert property ($rose(partial_powerdown_flag) |-> take_reset_vec)
        else $error("flag without reset vector");
    a_flag_ack:
    assert property ($fell(partial_powerdown_flag) |->
        $past(partial_powerdown_ack)) else $error("flag cleared early");
    a_vector_clocks:
    assert property (take_irq_vec || take_reset_vec |-> bus_clk_en
        && cpu_clk_en) else $error("fetch without clocks");
endmodule
bind smpc_stop_mode_power_controller smpc_monitor u_smpc_monitor (.*);
`default_nettype wire

/* test/smpc_host_model.sv */
`default_nettype none
module smpc_host_model #(
    parameter logic [7:0] SAVED = 8'h5a
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // device status
    input wire logic take_reset_vec,
    input wire logic partial_powerdown_flag,
    // software register writes
    output logic [7:0] port_ctrl = 8'h00,
    output logic partial_powerdown_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] step_q;
    // reset vector clears ports; saved ports go back before the ack
    always @(posedge clock)
    begin
        if (rst || take_reset_vec)
        begin
            step_q <= 2'h0;
            port_ctrl <= 8'h00;
            partial_powerdown_ack <= 1'b0;
        end
        else
        begin
            partial_powerdown_ack <= step_q == 2'h1;
            if (step_q != 2'h0)
                step_q <= 2'h2;
            else if (partial_powerdown_flag)
            begin
                port_ctrl <= SAVED;
                step_q <= 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* test/smpc_stop_mode_power_controller_bench.sv */
`default_nettype none
module smpc_stop_mode_power_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, any_irq_req = 1'b0, supply_low = 1'b0;
    logic reset_pin_n = 1'b1, irq_pin_n = 1'b1;
    logic [3:0] ev = 4'h0, wk = 4'h0;
    logic [7:0] cfg = 8'h00, periph_en = 8'h0f, periph_ctrl = 8'ha5;
    wire stop_exec, wait_exec, bgnd_cmd, mem_stat_cmd, stop_enable_bit;
    wire debug_enable_bit, lowvolt_detect_enable, lowvolt_detect_stop_enable;
    wire partial_powerdown_control, internal_refclk_enable, adc_async_clk_sel;
    wire internal_ref_stop_enable, sci_async_irq, adc_async_irq;
    wire low_voltage_warning_irq, irq_async_irq;
    wire partial_powerdown_ack, bus_clk_en;
    wire cpu_clk_en, periph_clk_en, debug_clk_en, refclk_run, adc_run;
    wire regulator_full, core_power_on, illegal_op_reset, por_reset;
    wire lvd_reset_en, lvd_low_trip, take_reset_vec, take_irq_vec;
    wire clear_int_mask, enter_bgnd, mem_access_en, partial_powerdown_flag;
    wire [1:0] mem_stat, mode_o;
    wire [7:0] port_ctrl, pin_ctrl_o;
    wire [3:0] ans = {enter_bgnd, !partial_powerdown_flag, take_reset_vec,
        take_irq_vec};
    int fail_count = 0, checks = 0, cyc = 0, n;
    // grouped drives keep each scenario to a few lines
    assign {stop_exec, wait_exec, bgnd_cmd, mem_stat_cmd} = ev;
    assign {stop_enable_bit, debug_enable_bit, lowvolt_detect_enable,
        lowvolt_detect_stop_enable, partial_powerdown_control,
        internal_refclk_enable, internal_ref_stop_enable,
        adc_async_clk_sel} = cfg;
    assign {sci_async_irq, adc_async_irq, low_voltage_warning_irq,
        irq_async_irq} = wk;
    smpc_stop_mode_power_controller u_smpc_stop_mode_power_controller (.*);
    smpc_host_model u_smpc_host_model (.*);
    always #4 clock = ~clock;
    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    // one-cycle event pulse; outputs of the taking edge are then visible
    task automatic fire(input logic [3:0] e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= 4'h0;
        #1;
    endtask
    // bounded wait for any answer selected by the mask
    task automatic await(input logic [3:0] m);
        for (n = 0; n < 40 && (ans & m) === 4'h0; n++)
            tick(1);
    endtask
    task automatic t_reset();
        @(posedge clock);
        rst <= 1'b1;
        tick(2);
        @(posedge clock);
        rst <= 1'b0;
        tick(1);
        // ports are cleared by reset, so enabled peripherals alone drive
        chk({bus_clk_en, cpu_clk_en, mem_access_en, mode_o, mem_stat,
            partial_powerdown_flag, pin_ctrl_o},
            {8'he0, periph_ctrl & periph_en});
    endtask
    task automatic t_illegal();
        @(posedge clock);
        cfg <= 8'h00;
        fire(4'h8);
        chk({illegal_op_reset, mode_o}, 3'h4);
    endtask
    // each stop3 row, woken by each async source and then the reset pin
    task automatic t_stop3();
        logic [7:0] rows [5] = '{8'hcf, 8'hb9, 8'ha6, 8'h84, 8'h82};
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clock);
            cfg <= rows[k];
            fire(4'h8);
            chk({mode_o, periph_clk_en, debug_clk_en, refclk_run}, {2'h2,
                1'b0, rows[k][6], rows[k][2] & rows[k][1]});
            @(posedge clock);
            wk <= (k < 4) ? 4'h8 >> k : 4'h0;
            reset_pin_n <= k != 4;
            await(4'h3);
            chk(ans[1:0], k < 4 ? 2'h1 : 2'h2);
            @(posedge clock);
            wk <= 4'h0;
            reset_pin_n <= 1'b1;
        end
    endtask
    // stop2 round trip: latch, refused wake, low supply, recovery
    task automatic t_stop2();
        @(posedge clock);
        cfg <= 8'h88;
        fire(4'h8);
        @(posedge clock);
        periph_ctrl <= 8'h3c;
        wk <= 4'h8;
        tick(4);
        chk({mode_o, core_power_on, pin_ctrl_o}, 11'h605);
        @(posedge clock);
        wk <= 4'h0;
        supply_low <= 1'b1;
        irq_pin_n <= 1'b0;
        tick(20);
        chk({por_reset, pin_ctrl_o}, 9'h105);
        @(posedge clock);
        supply_low <= 1'b0;
        irq_pin_n <= 1'b1;
        await(4'h2);
        chk({take_reset_vec, partial_powerdown_flag, lvd_reset_en,
            lvd_low_trip, pin_ctrl_o}, 12'hf05);
        await(4'h4);
        tick(1);
        chk(pin_ctrl_o, 8'h5c);
    endtask
    task automatic t_wait();
        fire(4'h4);
        chk({mode_o, cpu_clk_en, clear_int_mask}, 4'h5);
        @(posedge clock);
        any_irq_req <= 1'b1;
        await(4'h1);
        chk(take_irq_vec, 1'b1);
        @(posedge clock);
        any_irq_req <= 1'b0;
    endtask
    // debug host in stop3: status command refused, background wakes
    task automatic t_debug();
        @(posedge clock);
        cfg <= 8'hc0;
        fire(4'h8);
        fire(4'h1);
        chk({mode_o, mem_access_en, mem_stat, regulator_full},
            6'h25);
        fire(4'h2);
        await(4'h8);
        chk(enter_bgnd, 1'b1);
        t_reset();
    endtask
    initial
    begin
        t_reset();
        t_illegal();
        t_stop3();
        t_stop2();
        t_wait();
        t_debug();
        final_report();
    end
endmodule
`default_nettype wire
